// ### rtl/sleep_cue_controller.sv
// Operation
// R1: Dial position one plays host cue profile
// R2: Preset positions use fixed cue values
// R3: Factory profile 10, 3, 2, kind 2
// R4: Flash and click during host upload
// R5: Mode only from dial, never host
// R6: Entering sleep position plays cue once
// R7: One-second hold or re-entry replays cue
// R8: One-second hold zeroes hold-off countdown
// R9: Short press gives quick flash and chirp
// R10: Each short press adds ten minutes
// R11: Dial off restores configured hold-off
// R12: Initial hold-off is setting times ten minutes
// R13: No recording or cues during hold-off
// R14: Debounce button, classify short press or hold
`timescale 1ns/1ns
module sleep_cue_controller
	import sleep_cue_pkg::*;
#(
	parameter longint HOLD_CYCLES     = HOLD_CYC,
	parameter longint DEBOUNCE_CYCLES = DEBOUNCE_CYC,
	parameter longint TEN_MIN_CYCLES  = TEN_MIN_CYC,
	parameter longint FLASH_CYCLES    = FLASH_CYC,
	parameter longint RATE_BASE       = CLK_HZ
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [2:0]  dial,
	input  wire logic        button,
	input  wire logic        uploadActive,
	output logic             ledLeft,
	output logic             ledRight,
	output logic             speaker,
	output logic [2:0]       cueLevel,
	output logic             monitorEnable
);

	localparam logic [39:0] ONE = 40'h1;

	// Synchronisers for pins
	logic [2:0]  dialSync_ff;
	logic        btnSync_ff;
	logic        upSync_ff;

	pin_sync #(.WIDTH(3)) dialSyncer (
		.ref_clk (ref_clk),
		.din     (dial),
		.dout    (dialSync_ff)
	);
	pin_sync #(.WIDTH(1)) btnSyncer (
		.ref_clk (ref_clk),
		.din     (button),
		.dout    (btnSync_ff)
	);
	pin_sync #(.WIDTH(1)) upSyncer (
		.ref_clk (ref_clk),
		.din     (uploadActive),
		.dout    (upSync_ff)
	);

	// Registers
	cue_s        profile_ff;
	logic [5:0]  delaySet_ff;
	logic [2:0]  dialPrev_ff;

	wire         apbAccess  = psel && penable;
	wire         wrProfile  = apbAccess && pwrite && (paddr == ADDR_PROFILE);
	wire         wrSetup    = apbAccess && pwrite && (paddr == ADDR_SETUP);
	wire         addrKnown  = (paddr == ADDR_PROFILE) || (paddr == ADDR_SETUP) ||
	                          (paddr == ADDR_STATUS) || (paddr == ADDR_UPLOAD);
	wire         roWrite    = pwrite && ((paddr == ADDR_STATUS) || (paddr == ADDR_UPLOAD));
	wire  [5:0]  setupVal   = pwdata[DELAY_LSB +: 6];
	wire  [5:0]  setupClip  = (setupVal > MAX_DELAY) ? MAX_DELAY : setupVal;

	// Profile writes always land; dial one and the unassigned positions 5..7 play them [R2]
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			profile_ff  <= '{kind: RST_KIND, rate: RST_RATE, level: RST_INT,
			                 len: RST_LEN}; // [R3]
			delaySet_ff <= RST_DELAY;
		end else begin
			if (wrProfile) begin
				profile_ff.len   <= pwdata[LEN_LSB +: 8];
				profile_ff.level <= pwdata[INT_LSB +: 3];
				profile_ff.rate  <= pwdata[RATE_LSB +: 3];
				profile_ff.kind  <= pwdata[KIND_LSB +: 3];
			end
			if (wrSetup) begin
				delaySet_ff <= setupClip;
			end
		end
	end

	// Button debounce and press timing
	logic [39:0] stableCnt_ff, pressCnt_ff;
	logic        btnClean_ff, holdDone_ff;

	wire         btnDiffer  = btnSync_ff != btnClean_ff;
	wire         btnSettled = btnDiffer && (stableCnt_ff >= 40'(DEBOUNCE_CYCLES - 1));
	wire         btnRise    = btnSettled && btnSync_ff;
	wire         btnFall    = btnSettled && !btnSync_ff;
	wire         holdHit    = btnClean_ff && !holdDone_ff &&
	                          (pressCnt_ff >= 40'(HOLD_CYCLES - 1)); // [R14]
	wire         shortPress = btnFall && !holdDone_ff; // [R14]

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stableCnt_ff <= '0;
			btnClean_ff  <= 1'b0;
		end else begin
			stableCnt_ff <= btnDiffer && !btnSettled ? stableCnt_ff + ONE : '0; // [R14]
			if (btnSettled) begin
				btnClean_ff <= btnSync_ff;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst || btnRise) begin
			pressCnt_ff <= '0;
			holdDone_ff <= 1'b0;
		end else if (btnClean_ff && !holdDone_ff) begin
			pressCnt_ff <= pressCnt_ff + ONE;
			holdDone_ff <= holdHit;
		end
	end

	// Dial decode: mode comes only from the pin, no register can steer it [R5]
	wire         inSleep    = dialSync_ff != DIAL_OFF;
	wire         wasSleep   = dialPrev_ff != DIAL_OFF;
	wire         enterSleep = inSleep && (dialSync_ff != dialPrev_ff);
	wire         leaveSleep = !inSleep && wasSleep;

	always_ff @(posedge ref_clk) begin
		dialPrev_ff <= srst ? DIAL_OFF : dialSync_ff;
	end

	cue_s        activeCue;
	always_comb begin
		unique case (dialSync_ff)
			DIAL_ADJ: activeCue = profile_ff;   // [R1]
			3'h2:     activeCue = PRESET_LIGHT;  // [R2]
			3'h3:     activeCue = PRESET_MEDIUM; // [R2]
			3'h4:     activeCue = PRESET_DEEP;   // [R2]
			default:  activeCue = profile_ff;
		endcase
	end

	// Hold-off countdown in ten-minute units plus a sub-unit counter
	logic [9:0]  holdUnits_ff;
	logic [39:0] unitCnt_ff;
	logic        armed_ff;

	wire         holdRun    = holdUnits_ff != '0;
	wire         unitDone   = unitCnt_ff >= 40'(TEN_MIN_CYCLES - 1);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			holdUnits_ff <= '0;
			unitCnt_ff   <= '0;
			armed_ff     <= 1'b0;
		end else if (!inSleep) begin
			holdUnits_ff <= 10'(delaySet_ff); // [R11] [R12]
			unitCnt_ff   <= '0;
			armed_ff     <= 1'b0;
		end else begin
			armed_ff <= 1'b1;
			if (holdHit) begin
				holdUnits_ff <= '0; // [R8]
				unitCnt_ff   <= '0;
			end else if (shortPress) begin
				holdUnits_ff <= holdUnits_ff + 10'h001; // [R10]
			end else if (holdRun && armed_ff) begin
				unitCnt_ff <= unitDone ? '0 : unitCnt_ff + ONE; // [R12]
				if (unitDone) begin
					holdUnits_ff <= holdUnits_ff - 10'h001;
				end
			end
		end
	end

	// Eye-movement recording gated off while the countdown runs
	assign monitorEnable = inSleep && !holdRun; // [R13]

	// Cue player
	cue_state_e  cueState_ff;
	cue_s        playCue_ff;
	logic [39:0] phaseCnt_ff;
	logic [7:0]  flashLeft_ff;
	logic        side_ff;
	logic [39:0] confirmCnt_ff;

	// Demo cue bypasses the hold-off: it is the user's own request [R6] [R7]
	// A hold while off has no active cue to show
	wire         startCue   = enterSleep || (holdHit && inSleep);
	wire  [39:0] halfPeriod = 40'(RATE_BASE / 2) /
	                          {37'h0, (playCue_ff.rate == '0) ? 3'h1 : playCue_ff.rate};
	wire         phaseDone  = phaseCnt_ff >= halfPeriod - ONE;

	always_ff @(posedge ref_clk) begin
		if (srst || leaveSleep) begin
			cueState_ff  <= CUE_IDLE;
			playCue_ff   <= profile_ff;
			phaseCnt_ff  <= '0;
			flashLeft_ff <= '0;
			side_ff      <= 1'b0;
		end else if (startCue) begin
			cueState_ff  <= CUE_ON; // [R6] [R7]
			playCue_ff   <= activeCue;
			phaseCnt_ff  <= '0;
			flashLeft_ff <= activeCue.len;
			side_ff      <= 1'b0;
		end else begin
			phaseCnt_ff <= (cueState_ff == CUE_IDLE || phaseDone) ? '0 : phaseCnt_ff + ONE;
			unique case (cueState_ff)
				CUE_IDLE: cueState_ff <= CUE_IDLE;
				CUE_ON: begin
					if (phaseDone) begin
						cueState_ff  <= CUE_OFF;
						flashLeft_ff <= flashLeft_ff - 8'h01;
					end
				end
				CUE_OFF: begin
					if (phaseDone) begin
						side_ff     <= !side_ff;
						cueState_ff <= (flashLeft_ff == '0) ? CUE_IDLE : CUE_ON;
					end
				end
			endcase
		end
	end

	// Confirmation flash and chirp
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			confirmCnt_ff <= '0;
		end else if (!inSleep) begin
			confirmCnt_ff <= '0; // Off must stay dark
		end else if (shortPress) begin
			confirmCnt_ff <= 40'(FLASH_CYCLES); // [R9]
		end else if (confirmCnt_ff != '0) begin
			confirmCnt_ff <= confirmCnt_ff - ONE;
		end
	end

	// Upload activity: both lights blink, the speaker ticks as each blink starts.
	// The blink step shares the confirmation length, so one count sets both
	logic [39:0] upCnt_ff;
	logic        upPhase_ff;
	wire         upStep     = upCnt_ff >= 40'(FLASH_CYCLES - 1);

	always_ff @(posedge ref_clk) begin
		if (srst || !upSync_ff) begin
			upCnt_ff   <= '0;
			upPhase_ff <= 1'b1;
		end else begin
			upCnt_ff   <= upStep ? '0 : upCnt_ff + ONE;
			upPhase_ff <= upStep ? !upPhase_ff : upPhase_ff;
		end
	end
	wire         upBlink    = upSync_ff && upPhase_ff; // [R4]
	wire         upClick    = upSync_ff && upPhase_ff && (upCnt_ff == '0); // [R4]

	// Output drive; kinds 0, 6 and 7 drive no light and no sound
	kind_s       kindDec;
	always_comb begin
		unique case (playCue_ff.kind)
			3'h1:    kindDec = '{light: 1'b1, sound: 1'b0, alternate: 1'b0};
			3'h2:    kindDec = '{light: 1'b1, sound: 1'b0, alternate: 1'b1};
			3'h3:    kindDec = '{light: 1'b0, sound: 1'b1, alternate: 1'b0};
			3'h4:    kindDec = '{light: 1'b1, sound: 1'b1, alternate: 1'b0};
			3'h5:    kindDec = '{light: 1'b1, sound: 1'b1, alternate: 1'b1};
			default: kindDec = '{light: 1'b0, sound: 1'b0, alternate: 1'b0};
		endcase
	end

	wire         cueOn      = cueState_ff == CUE_ON;
	wire         confirmOn  = confirmCnt_ff != '0;
	wire         litL       = cueOn && kindDec.light && !(kindDec.alternate && side_ff);
	wire         litR       = cueOn && kindDec.light && !(kindDec.alternate && !side_ff);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ledLeft  <= 1'b0;
			ledRight <= 1'b0;
			speaker  <= 1'b0;
			cueLevel <= '0;
		end else begin
			ledLeft  <= litL || confirmOn || upBlink;
			ledRight <= litR || confirmOn || upBlink;
			speaker  <= (cueOn && kindDec.sound) || confirmOn || upClick;
			cueLevel <= cueOn ? playCue_ff.level : RST_INT;
		end
	end

	// APB read path, zero-wait
	wire  [31:0] statusWord = {16'h0, holdUnits_ff, monitorEnable, holdRun, cueOn, dialSync_ff};
	wire  [31:0] rdMux      = (paddr == ADDR_PROFILE) ?
	                          {13'h0, profile_ff.kind, 1'b0, profile_ff.rate, 1'b0,
	                           profile_ff.level, profile_ff.len} :
	                          (paddr == ADDR_SETUP)   ? {26'h0, delaySet_ff} :
	                          (paddr == ADDR_STATUS)  ? statusWord :
	                          (paddr == ADDR_UPLOAD)  ? {31'h0, upSync_ff} : 32'h0;

	assign pready  = 1'b1;
	assign pslverr = apbAccess && (!addrKnown || roWrite);

	// Read data is captured in setup so the access phase needs no wait state
	wire         rdCapture  = psel && !penable && !pwrite;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			prdata <= '0;
		end else if (rdCapture) begin
			prdata <= rdMux;
		end
	end

endmodule : sleep_cue_controller

// Two-flop synchroniser for one pin or a group of pins
module pin_sync
	import sleep_cue_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             ref_clk,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_ff;

	// Only the second stage feeds logic, giving the first a cycle to settle
	always_ff @(posedge ref_clk) begin
		meta_ff <= din;
		dout    <= meta_ff;
	end

endmodule : pin_sync

// ### rtl/sleep_cue_pkg.sv
package sleep_cue_pkg;

	// APB register byte addresses
	localparam logic [7:0]  ADDR_PROFILE   = 8'h00;
	localparam logic [7:0]  ADDR_SETUP     = 8'h04;
	localparam logic [7:0]  ADDR_STATUS    = 8'h08;
	localparam logic [7:0]  ADDR_UPLOAD    = 8'h0C;

	// Profile field layout
	localparam int          LEN_LSB        = 0;
	localparam int          INT_LSB        = 8;
	localparam int          RATE_LSB       = 12;
	localparam int          KIND_LSB       = 16;
	localparam int          DELAY_LSB      = 0;

	// Factory adjustable profile
	localparam logic [7:0]  RST_LEN        = 8'h0A;
	localparam logic [2:0]  RST_INT        = 3'h3;
	localparam logic [2:0]  RST_RATE       = 3'h2;
	localparam logic [2:0]  RST_KIND       = 3'h2;
	localparam logic [5:0]  RST_DELAY      = 6'h00;
	localparam logic [5:0]  MAX_DELAY      = 6'h3C;

	// Dial positions
	localparam logic [2:0]  DIAL_OFF       = 3'h0;
	localparam logic [2:0]  DIAL_ADJ       = 3'h1;

	// Timing
	localparam longint      CLK_HZ         = 100000000;
	localparam longint      HOLD_MS        = 1000;
	localparam longint      DEBOUNCE_MS    = 20;
	localparam longint      TEN_MIN_S      = 600;
	localparam longint      FLASH_MS       = 50;
	localparam longint      HOLD_CYC       = CLK_HZ / 1000 * HOLD_MS;
	localparam longint      DEBOUNCE_CYC   = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam longint      TEN_MIN_CYC    = CLK_HZ * TEN_MIN_S;
	localparam longint      FLASH_CYC      = CLK_HZ / 1000 * FLASH_MS;

	typedef struct packed {
		logic [2:0] kind;
		logic [2:0] rate;
		logic [2:0] level;
		logic [7:0] len;
	} cue_s;

	typedef struct packed {
		logic       light;
		logic       sound;
		logic       alternate;
	} kind_s;

	// Preset cue profiles for dial positions 2..4; values arbitrary
	localparam cue_s PRESET_LIGHT  = '{kind: 3'h1, rate: 3'h2, level: 3'h2, len: 8'h08};
	localparam cue_s PRESET_MEDIUM = '{kind: 3'h4, rate: 3'h3, level: 3'h4, len: 8'h0C};
	localparam cue_s PRESET_DEEP   = '{kind: 3'h5, rate: 3'h4, level: 3'h6, len: 8'h10};

	typedef enum logic [1:0] {
		CUE_IDLE,
		CUE_ON,
		CUE_OFF
	} cue_state_e;

endpackage : sleep_cue_pkg

// ### bench/upload_host.sv
`timescale 1ns/1ns
module upload_host (
	input  wire logic ref_clk,
	input  wire logic go,
	output logic      uploadActive
);
	// Box keeps the transfer line up for the whole settings upload
	always_ff @(posedge ref_clk) begin
		uploadActive <= go;
	end
endmodule : upload_host

// ### bench/sleep_cue_sva.sv
`timescale 1ns/1ns
module sleep_cue_sva
	import sleep_cue_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [2:0]  dial,
	input wire logic        button,
	input wire logic        uploadActive,
	input wire logic        ledLeft,
	input wire logic        ledRight,
	input wire logic        speaker,
	input wire logic [2:0]  cueLevel,
	input wire logic        monitorEnable
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	wire logic acc = psel && penable;
	property p_rdy; acc |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready low in access");
	property p_errWr; acc && pwrite && paddr == ADDR_STATUS |-> pslverr; endproperty
	a_errWr: assert property (p_errWr) else $error("status write accepted");
	property p_errOk; acc && paddr == ADDR_PROFILE |-> !pslverr; endproperty
	a_errOk: assert property (p_errOk) else $error("profile access refused");
	property p_errIdle; !acc |-> !pslverr; endproperty
	a_errIdle: assert property (p_errIdle) else $error("pslverr outside access");
	property p_rdHold; acc && !pwrite |=> prdata == $past(prdata); endproperty
	a_rdHold: assert property (p_rdHold) else $error("read data not held");
	property p_offQuiet;
		(dial == DIAL_OFF && !uploadActive) [*6] |->
			!ledLeft && !ledRight && !speaker && cueLevel == 3'h3;
	endproperty
	a_offQuiet: assert property (p_offQuiet) else $error("output while off");
	property p_presetLvl;
		(dial == 3'h2 && !uploadActive) [*6] |-> cueLevel inside {3'h3, PRESET_LIGHT.level};
	endproperty
	a_presetLvl: assert property (p_presetLvl) else $error("preset level wrong");
	property p_monOff; dial == DIAL_OFF [*4] |-> !monitorEnable; endproperty
	a_monOff: assert property (p_monOff) else $error("monitor on while off");
endmodule : sleep_cue_sva
bind sleep_cue_controller sleep_cue_sva chk (.*);

// ### bench/testbench.sv
`timescale 1ns/1ns
module testbench
	import sleep_cue_pkg::*;
;
	logic        ref_clk, srst, psel, penable, pwrite, button, go, err, flash, click;
	logic        pready, pslverr, ledLeft, ledRight, speaker, uploadActive, monitorEnable;
	logic [2:0]  dial, cueLevel;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          fail_count, checks;

	// Short counts keep the run to a few thousand cycles
	sleep_cue_controller #(.HOLD_CYCLES(50), .DEBOUNCE_CYCLES(4), .TEN_MIN_CYCLES(2000),
		.FLASH_CYCLES(5), .RATE_BASE(40)) dut (.*);
	upload_host host (.ref_clk, .go, .uploadActive);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task waitLvl(input logic [2:0] lv);
		for (int i = 0; i < 400 && cueLevel !== lv; i++) @(posedge ref_clk);
	endtask : waitLvl

	// Samples every cycle so a five-cycle flash is not missed
	task press(input int n);
		flash = 1'b0;
		button <= 1'b1;
		for (int i = 0; i < n + 40; i++) begin
			@(posedge ref_clk);
			if (i == n) button <= 1'b0;
			if (ledLeft === 1'b1 && ledRight === 1'b1) flash = 1'b1;
		end
	endtask : press

	task print_verdict;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		print_verdict();
	end

	initial begin
		{srst, psel, penable, pwrite, button, go} = 6'h20;
		{dial, paddr, pwdata} = '0;
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		apb(1'b0, ADDR_PROFILE, 32'h0); chk(rd, 32'h0002230A);
		apb(1'b1, ADDR_SETUP, 32'h3D);
		apb(1'b0, ADDR_SETUP, 32'h0); chk(rd, 32'h3C);
		apb(1'b1, ADDR_STATUS, 32'h4); chk(err, 1);
		apb(1'b0, ADDR_STATUS, 32'h0); chk(rd[2:0], DIAL_OFF);
		apb(1'b0, 8'h10, 32'h0); chk(err, 1);
		apb(1'b1, ADDR_SETUP, 32'h1);
		apb(1'b1, ADDR_PROFILE, 32'h00014520);
		$display("test registers done");
		dial <= DIAL_ADJ;
		waitLvl(3'h5); chk(cueLevel, 3'h5);
		chk(monitorEnable, 0);
		repeat (2100) @(posedge ref_clk);
		chk(monitorEnable, 1);
		$display("test dial entry done");
		repeat (3) begin
			press(20); chk(flash, 1);
		end
		chk(monitorEnable, 0);
		apb(1'b0, ADDR_STATUS, 32'h0); chk(rd[15:6], 3);
		$display("test short press done");
		press(80); chk(cueLevel, 3'h5);
		chk(monitorEnable, 1);
		apb(1'b0, ADDR_STATUS, 32'h0); chk(rd[15:6], 0);
		$display("test hold done");
		dial <= DIAL_OFF;
		repeat (400) @(posedge ref_clk);
		apb(1'b0, ADDR_STATUS, 32'h0); chk(rd[15:6], 1);
		dial <= DIAL_ADJ;
		waitLvl(3'h5); chk(cueLevel, 3'h5);
		dial <= 3'h2;
		waitLvl(PRESET_LIGHT.level); chk(cueLevel, PRESET_LIGHT.level);
		dial <= 3'h3;
		waitLvl(PRESET_MEDIUM.level); chk(cueLevel, PRESET_MEDIUM.level);
		dial <= 3'h4;
		waitLvl(PRESET_DEEP.level); chk(cueLevel, PRESET_DEEP.level);
		$display("test dial change done");
		// Let the preset cue end so only upload activity can light or sound
		repeat (200) @(posedge ref_clk);
		{flash, click} = 2'h0;
		go <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			@(posedge ref_clk);
			if (ledLeft === 1'b1 && ledRight === 1'b1) flash = 1'b1;
			if (speaker === 1'b1) click = 1'b1;
		end
		chk(flash, 1);
		chk(click, 1);
		apb(1'b0, ADDR_UPLOAD, 32'h0); chk(rd[0], 1);
		go <= 1'b0;
		$display("test upload done");
		print_verdict();
	end
endmodule : testbench
